//--- rtl/lsu_unit.sv
`timescale 1ns/100ps
`include "lsu_consts.svh"
module lsu_unit #(
   parameter bit PREFETCH_EN = 1'b1,
   parameter int LOAD_LAT = `LSU_LOAD_LAT
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_req_valid,
   input wire lsu_pkg::lsu_req_s i_req,
   output logic o_req_ready,
   input wire logic i_um_wr,
   input wire logic [`LSU_UM_W-1:0] i_um_data,
   output logic o_big_endian_select,
   output logic o_dc_valid,
   output lsu_pkg::lsu_dc_req_s o_dc_req,
   input wire logic i_dc_ready,
   input wire logic i_dc_rvalid,
   input wire logic [`LSU_QW_W-1:0] i_dc_rdata,
   output logic o_ld_valid,
   output lsu_pkg::lsu_ld_rsp_s o_ld_rsp,
   output logic o_ld_busy,
   output logic [`LSU_TAG_W-1:0] o_ld_busy_tag,
   output logic o_err
);
   import lsu_pkg::*;

   // The sequencing below is built for exactly two cycles
   if (LOAD_LAT != 2)
   begin : g_bad_lat
      $error("lsu_unit supports only a load latency of 2");
   end

   lsu_state_e st_q;
   lsu_state_e st_d;
   lsu_req_s cur_q;
   logic cur_big_q;
   logic be_q;
   logic take;
   logic legal;
   logic send;
   logic [127:0] src;
   logic [127:0] wide;
   logic [15:0] lanes;
   logic beat2_q;
   logic [7:0] beat2_be_q;
   logic [`LSU_QW_W-1:0] beat2_data_q;
   logic fmt_valid;

   assign take = i_req_valid && o_req_ready;
   assign legal = lsu_legal(i_req.kind, i_req.size, i_req.addr[2:0]);
   // A disabled prefetch is swallowed without touching the cache
   // (R9) hint may be ignored
   assign send = take && legal && !(i_req.kind == LSU_PF && !PREFETCH_EN);

   // Endian select from the user mask, little endian out of reset
   // (R4) little endian default
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         be_q <= 1'(`LSU_UM_RST >> `LSU_UM_BE_BIT);
      else if (i_um_wr)
         be_q <= i_um_data[`LSU_UM_BE_BIT];
   end
   assign o_big_endian_select = be_q;

   // Store data placed on its byte lanes
   // (R5) big endian swap
   always_comb
   begin
      // (R8) full quadword source
      if (i_req.kind == LSU_ST)
         src = {64'h0, i_req.data[`LSU_QW_W-1:0]};
      else
         src = {48'h0, i_req.data};
      // (R3) low bytes only
      wide = lsu_order(src, i_req.size, be_q) << {i_req.addr[2:0], 3'b000};
      lanes = lsu_lanes(i_req.size) << i_req.addr[2:0];
   end

   // Sequencer, one access in flight at a time
   // (R11) program order kept
   // (R12) later store lands last
   always_comb
   begin
      st_d = st_q;
      case (st_q)
         ST_IDLE:
            if (send)
               st_d = ST_SEND;
         ST_SEND:
            if (i_dc_ready && !beat2_q)
               st_d = (cur_q.kind == LSU_LD) ? ST_LDWAIT : ST_IDLE;
         ST_LDWAIT:
            if (i_dc_rvalid)
               st_d = ST_IDLE;
         default:
            st_d = ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         st_q <= ST_IDLE;
      else
         st_q <= st_d;
   end

   // Request acceptance, only while nothing is outstanding
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         o_req_ready <= 1'b1;
      else
         o_req_ready <= (st_d == ST_IDLE) && !send;
   end

   // Held copy of the accepted operation and its byte order
   // (R15) order captured at issue
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         cur_q <= '0;
         cur_big_q <= 1'b0;
      end
      else if (send)
      begin
         cur_q <= i_req;
         cur_big_q <= be_q;
      end
   end

   // Cache beats; a ten byte store spills into a second quadword
   // (R2) ten byte store
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_dc_valid <= 1'b0;
         o_dc_req <= '0;
         beat2_q <= 1'b0;
         beat2_be_q <= 8'h00;
         beat2_data_q <= '0;
      end
      else if (send)
      begin
         o_dc_valid <= 1'b1;
         // (R1) store width
         o_dc_req.wr <= (i_req.kind == LSU_ST) || (i_req.kind == LSU_STF);
         o_dc_req.pf <= (i_req.kind == LSU_PF);
         o_dc_req.addr <= {i_req.addr[`LSU_ADDR_W-1:3], 3'b000};
         // (R6) load width
         o_dc_req.be <= (i_req.kind == LSU_PF) ? 8'h00 : lanes[7:0];
         o_dc_req.wdata <= (i_req.kind == LSU_PF) ? '0 : wide[63:0];
         beat2_q <= (i_req.kind == LSU_STF) && (|lanes[15:8]);
         beat2_be_q <= lanes[15:8];
         beat2_data_q <= wide[127:64];
      end
      else if (st_q == ST_SEND && i_dc_ready)
      begin
         if (beat2_q)
         begin
            o_dc_req.addr <= o_dc_req.addr + `LSU_ADDR_W'(8);
            o_dc_req.be <= beat2_be_q;
            o_dc_req.wdata <= beat2_data_q;
            beat2_q <= 1'b0;
         end
         else
            o_dc_valid <= 1'b0;
      end
   end

   // Scoreboard for the target of the pending load
   // (R14) dependent use stalls
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_ld_busy <= 1'b0;
         o_ld_busy_tag <= '0;
      end
      else if (send && i_req.kind == LSU_LD)
      begin
         o_ld_busy <= 1'b1;
         o_ld_busy_tag <= i_req.tag;
      end
      else if (fmt_valid)
         o_ld_busy <= 1'b0;
   end

   // Unsupported size or misaligned address, dropped
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         o_err <= 1'b0;
      else
         o_err <= take && !legal;
   end

   // Load return formatting
   // (R13) load after store sees it
   assign fmt_valid = (st_q == ST_LDWAIT) && i_dc_rvalid;

   lsu_ld_fmt u_fmt (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_valid(fmt_valid),
      .i_rdata(i_dc_rdata),
      .i_off(cur_q.addr[2:0]),
      .i_size(cur_q.size),
      .i_big(cur_big_q),
      .i_tag(cur_q.tag),
      .o_valid(o_ld_valid),
      .o_rsp(o_ld_rsp)
   );

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   AST_ST_WIDTH: assert property (send && i_req.kind == LSU_ST |=> // R1
      o_dc_valid && o_dc_req.wr && $countones(o_dc_req.be) == int'($past(i_req.size)))
      else $error("integer store lane count wrong");

   AST_STF_TEN: assert property (send && i_req.kind == LSU_STF && i_req.size == `LSU_SZ_10 |=> // R2
      o_dc_valid && o_dc_req.be == 8'hFF && beat2_q && beat2_be_q == 8'h03)
      else $error("ten byte store first beat wrong");

   AST_STF_SPILL: assert property (st_q == ST_SEND && i_dc_ready && beat2_q |=> // R2
      o_dc_valid && o_dc_req.be == 8'h03 && o_dc_req.addr == $past(o_dc_req.addr) + 64'h8)
      else $error("ten byte store second beat wrong");

   AST_ST_LOW: assert property (send && i_req.kind == LSU_ST && i_req.size == `LSU_SZ_4 && // R3
      i_req.addr[2:0] == 3'h0 && !be_q |=>
      o_dc_req.be == 8'h0F && o_dc_req.wdata[31:0] == $past(i_req.data[31:0]))
      else $error("four byte store not low bytes");

   AST_LE_QUAD: assert property (send && i_req.kind == LSU_ST && !be_q && // R4
      i_req.size == `LSU_SZ_8 |=> o_dc_req.wdata == $past(i_req.data[63:0]))
      else $error("little endian store altered");

   AST_BE_SWAP: assert property (send && i_req.kind == LSU_ST && be_q && // R5
      i_req.size == `LSU_SZ_8 |=> o_dc_req.wdata[7:0] == $past(i_req.data[63:56]))
      else $error("big endian store not swapped");

   AST_LD_READ: assert property (send && i_req.kind == LSU_LD |=> // R6
      !o_dc_req.wr && $countones(o_dc_req.be) == int'($past(i_req.size)))
      else $error("load lane count wrong");

   AST_PF_SAFE: assert property (o_dc_valid && o_dc_req.pf |-> // R9
      !o_dc_req.wr && o_dc_req.be == 8'h00)
      else $error("prefetch would modify memory");

   AST_ONE_INFLIGHT: assert property (o_dc_valid || st_q == ST_LDWAIT |-> // R11
      !o_req_ready)
      else $error("new request accepted while access in flight");

   AST_LD_LAT: assert property (st_q == ST_SEND && cur_q.kind == LSU_LD && i_dc_ready // R14
      ##1 i_dc_rvalid |=> o_ld_valid && !o_ld_busy)
      else $error("load data not delivered in two cycles");

   AST_BUSY_HOLD: assert property (o_ld_busy && !fmt_valid |=> // R14
      o_ld_busy && o_ld_busy_tag == $past(o_ld_busy_tag))
      else $error("load target released early");

endmodule : lsu_unit

//--- rtl/lsu_consts.svh
// Behaviour
// (R1) Integer stores write 1, 2, 4 or 8 bytes
// (R2) Float stores write 4, 8 or 10 bytes
// (R3) Narrow store writes only low source bytes
// (R4) Little endian order after reset
// (R5) Big endian select bit swaps byte order
// (R6) Integer loads read 1, 2, 4 or 8 bytes
// (R7) Narrow loads zero-extend to 64 bits
// (R8) Integer datapath works on 64-bit quadwords
// (R9) Prefetch hint never changes architectural state
// (R10) Issuer places stops between register dependences
// (R11) Group accesses behave as sequential program order
// (R12) Later same-address store wins
// (R13) Load after overlapping store sees its data
// (R14) Load data two cycles after issue
// (R15) Same byte order for loads and stores
`ifndef LSU_CONSTS_SVH
`define LSU_CONSTS_SVH

// Address, data and tag widths
`define LSU_ADDR_W 64
`define LSU_QW_W 64
`define LSU_ST_W 80
`define LSU_TAG_W 7

// Access sizes in bytes
`define LSU_SZ_1 4'h1
`define LSU_SZ_2 4'h2
`define LSU_SZ_4 4'h4
`define LSU_SZ_8 4'h8
`define LSU_SZ_10 4'hA

// User mask layout and reset value
`define LSU_UM_W 8
`define LSU_UM_BE_BIT 1
`define LSU_UM_RST 8'h00

// Load-to-use latency in cycles
`define LSU_LOAD_LAT 2

`endif

//--- rtl/lsu_pkg.sv
`include "lsu_consts.svh"
package lsu_pkg;

   typedef logic [3:0] lsu_size_t;

   typedef enum logic [1:0] {LSU_LD, LSU_ST, LSU_STF, LSU_PF} lsu_kind_e;

   typedef enum {ST_IDLE, ST_SEND, ST_LDWAIT} lsu_state_e;

   // One memory operation from the issue pipeline
   typedef struct packed {
      lsu_kind_e kind;
      lsu_size_t size;
      logic [`LSU_ADDR_W-1:0] addr;
      logic [`LSU_ST_W-1:0] data;
      logic [`LSU_TAG_W-1:0] tag;
   } lsu_req_s;

   // One quadword beat towards the data cache
   typedef struct packed {
      logic wr;
      logic pf;
      logic [`LSU_ADDR_W-1:0] addr;
      logic [7:0] be;
      logic [`LSU_QW_W-1:0] wdata;
   } lsu_dc_req_s;

   // Load result towards the register file
   typedef struct packed {
      logic [`LSU_TAG_W-1:0] tag;
      logic [`LSU_QW_W-1:0] data;
   } lsu_ld_rsp_s;

   // Keep the low n bytes, reversed when big endian
   function automatic logic [127:0] lsu_order(input logic [127:0] d, input lsu_size_t n,
                                              input logic big);
      logic [127:0] r;
      r = '0;
      for (int i = 0; i < 16; i++)
         if (i < int'(n))
            r[8*i +: 8] = big ? d[8*(int'(n)-1-i) +: 8] : d[8*i +: 8];
      return r;
   endfunction : lsu_order

   // One lane bit per byte of the access
   function automatic logic [15:0] lsu_lanes(input lsu_size_t n);
      logic [15:0] r;
      r = '0;
      for (int i = 0; i < 16; i++)
         r[i] = (i < int'(n));
      return r;
   endfunction : lsu_lanes

   // Sizes each kind supports and natural alignment
   function automatic logic lsu_legal(input lsu_kind_e k, input lsu_size_t n,
                                      input logic [2:0] off);
      logic ok;
      case (k)
         LSU_LD, LSU_ST: ok = (n == `LSU_SZ_1) || (n == `LSU_SZ_2) || (n == `LSU_SZ_4) ||
                              (n == `LSU_SZ_8);
         LSU_STF: ok = (n == `LSU_SZ_4) || (n == `LSU_SZ_8) || (n == `LSU_SZ_10);
         default: ok = 1'b1;
      endcase
      if (k != LSU_PF && n != `LSU_SZ_10 && ok)
         ok = ((off & (3'(n) - 3'h1)) == 3'h0) || (n == `LSU_SZ_8 && off == 3'h0);
      if (n == `LSU_SZ_10)
         ok = ok && (off == 3'h0);
      return ok;
   endfunction : lsu_legal

endpackage : lsu_pkg

//--- rtl/lsu_ld_fmt.sv
`timescale 1ns/100ps
`include "lsu_consts.svh"
module lsu_ld_fmt (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_valid,
   input wire logic [`LSU_QW_W-1:0] i_rdata,
   input wire logic [2:0] i_off,
   input wire lsu_pkg::lsu_size_t i_size,
   input wire logic i_big,
   input wire logic [`LSU_TAG_W-1:0] i_tag,
   output logic o_valid,
   output lsu_pkg::lsu_ld_rsp_s o_rsp
);
   import lsu_pkg::*;

   logic [127:0] aligned;
   logic [127:0] ordered;

   // Bring the addressed byte down to lane zero, then order and trim
   // (R15) same ordering as stores
   assign aligned = {64'h0, i_rdata >> {i_off, 3'b000}};
   assign ordered = lsu_order(aligned, i_size, i_big);

   // Result strobe
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         o_valid <= 1'b0;
      else
         o_valid <= i_valid;
   end

   // Result data, bytes above the size cleared
   // (R7) zero extension
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         o_rsp <= '0;
      else if (i_valid)
      begin
         o_rsp.data <= ordered[`LSU_QW_W-1:0];
         o_rsp.tag <= i_tag;
      end
   end

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   AST_ZEXT_WORD: assert property (i_valid && i_size == `LSU_SZ_4 |=> // R7
      o_valid && o_rsp.data[63:32] == 32'h0)
      else $error("word load not zero-extended");

   AST_QUAD_LE: assert property (i_valid && i_size == `LSU_SZ_8 && !i_big |=> // R8
      o_rsp.data == $past(i_rdata))
      else $error("little endian quadword load altered");

endmodule : lsu_ld_fmt

//--- sim/lsu_mem_model.sv
`timescale 1ns/100ps
`include "lsu_consts.svh"
module lsu_mem_model (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_slow,
   input wire logic i_dc_valid,
   input wire lsu_pkg::lsu_dc_req_s i_dc_req,
   output logic o_dc_ready,
   output logic o_dc_rvalid,
   output logic [`LSU_QW_W-1:0] o_dc_rdata
);
   import lsu_pkg::*;
   logic [63:0] mem_q [32];
   logic take;

   // Beat accepted this edge
   assign take = i_dc_valid && o_dc_ready;

   // Ready, prompt or stalling at random
   always_ff @(posedge i_clk or negedge i_rstn)
      if (!i_rstn)
         o_dc_ready <= 1'b0;
      else
         o_dc_ready <= !i_slow || ($urandom % 3 == 0);

   // writes land in acceptance order, hints never write
   always_ff @(posedge i_clk or negedge i_rstn)
      if (!i_rstn)
         for (int i = 0; i < 32; i++)
            mem_q[i] <= '0;
      else if (take && i_dc_req.wr && !i_dc_req.pf)
         for (int i = 0; i < 8; i++)
            if (i_dc_req.be[i])
               mem_q[i_dc_req.addr[7:3]][8*i +: 8] <= i_dc_req.wdata[8*i +: 8];

   // Read data one cycle after acceptance, a moving pattern otherwise
   always_ff @(posedge i_clk or negedge i_rstn)
      if (!i_rstn)
      begin
         o_dc_rvalid <= 1'b0;
         o_dc_rdata <= '0;
      end
      else
      begin
         o_dc_rvalid <= take && !i_dc_req.wr && !i_dc_req.pf;
         o_dc_rdata <= (take && !i_dc_req.wr) ? mem_q[i_dc_req.addr[7:3]] : ~o_dc_rdata;
      end
endmodule : lsu_mem_model

//--- sim/lsu_unit_test.sv
`timescale 1ns/100ps
`include "lsu_consts.svh"
module lsu_unit_test;
   import lsu_pkg::*;
   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic req_valid = 1'b0;
   logic um_wr = 1'b0;
   logic slow = 1'b0;
   logic big = 1'b0;
   logic [7:0] um_data = 8'h00;
   lsu_req_s req = '0;
   logic ready, be_sel, dc_valid, dc_ready, dc_rvalid, ld_valid, ld_busy, err;
   lsu_dc_req_s dc_req;
   logic [63:0] dc_rdata;
   lsu_ld_rsp_s ld_rsp;
   logic [6:0] busy_tag;
   logic [6:0] tg;
   logic [7:0] ref_mem [256];
   int n_mismatch = 0;
   int comparisons = 0;
   int w;
   lsu_kind_e k;
   lsu_size_t n;
   logic [7:0] a;

   // Core clock
   always #20 i_clk = ~i_clk;

   lsu_unit i_lsu_unit (.i_clk(i_clk), .i_rstn(i_rstn), .i_req_valid(req_valid), .i_req(req),
      .o_req_ready(ready), .i_um_wr(um_wr), .i_um_data(um_data), .o_big_endian_select(be_sel),
      .o_dc_valid(dc_valid), .o_dc_req(dc_req), .i_dc_ready(dc_ready), .i_dc_rvalid(dc_rvalid),
      .i_dc_rdata(dc_rdata), .o_ld_valid(ld_valid), .o_ld_rsp(ld_rsp), .o_ld_busy(ld_busy),
      .o_ld_busy_tag(busy_tag), .o_err(err));

   lsu_mem_model i_lsu_mem_model (.i_clk(i_clk), .i_rstn(i_rstn), .i_slow(slow),
      .i_dc_valid(dc_valid), .i_dc_req(dc_req), .o_dc_ready(dc_ready),
      .o_dc_rvalid(dc_rvalid), .o_dc_rdata(dc_rdata));

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict

   task automatic check(input logic [79:0] got, input logic [79:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: %h versus %h", $time, got, exp);
      end
   endtask : check

   task automatic timeout;
      n_mismatch++;
      print_verdict;
   endtask : timeout

   // Memory byte holding lane i in the current order
   function automatic int pos(input logic [7:0] a, input lsu_size_t n, input int i);
      return 8'(int'(a) + (big ? int'(n) - 1 - i : i));
   endfunction : pos

   function automatic logic [79:0] ref_load(input logic [7:0] a, input lsu_size_t n);
      logic [79:0] v;
      v = '0;
      for (int i = 0; i < int'(n); i++)
         v[8*i +: 8] = ref_mem[pos(a, n, i)];
      return v;
   endfunction : ref_load

   // One request, then its beat, store image or load result
   task automatic issue(input lsu_kind_e k, input lsu_size_t n, input logic [7:0] a,
                        input logic [79:0] d, input bit ok);
      // one access at a time, no register hazard
      w = 0;
      do
      begin
         @(posedge i_clk);
         #1;
         w++;
      end
      while (!ready && w < 99);
      if (!ready)
         timeout;
      tg = 7'($urandom);
      req_valid = 1'b1;
      req = '{k, n, {56'h0, a}, d, tg};
      @(posedge i_clk);
      #1;
      req_valid = 1'b0;
      check(err, !ok);
      if (ok && k != LSU_PF && n != 4'hA)
         check(dc_req.be, 8'((16'h1 << n) - 16'h1) << a[2:0]);
      if (ok && (k == LSU_ST || k == LSU_STF))
         for (int i = 0; i < int'(n); i++)
            ref_mem[pos(a, n, i)] = d[8*i +: 8];
      if (ok && k == LSU_LD)
      begin
         check({ld_busy, busy_tag}, {1'b1, tg});
         for (w = 0; !ld_valid && w < 99; w++)
         begin
            @(posedge i_clk);
            #1;
         end
         if (!ld_valid)
            timeout;
         if (!slow)
            check(w, 2);
         check(ld_rsp, {tg, 64'(ref_load(a, n))});
         check(ld_busy, 1'b0);
      end
   endtask : issue

   task automatic set_order(input logic b);
      @(posedge i_clk);
      #1;
      um_data = 8'($urandom) & 8'hFD | {6'h0, b, 1'b0};
      um_wr = 1'b1;
      @(posedge i_clk);
      #1;
      um_wr = 1'b0;
      big = b;
      check(be_sel, b);
   endtask : set_order

   // Reset, corner cases, then random traffic
   initial
   begin
      w = $urandom(32'h9AE053CE);
      for (int i = 0; i < 256; i++)
         ref_mem[i] = 8'h00;
      repeat (8) @(posedge i_clk);
      #1;
      check({ready, be_sel, dc_valid}, 3'b100);
      i_rstn = 1'b1;
      issue(LSU_ST, 4'h4, 8'h04, 80'h1122334455, 1'b1);
      issue(LSU_LD, 4'h8, 8'h00, '0, 1'b1);
      issue(LSU_PF, 4'h8, 8'h00, '1, 1'b1);
      check({dc_valid, dc_req.pf, dc_req.wr}, 3'b110);
      issue(LSU_ST, 4'h3, 8'h00, '1, 1'b0);
      issue(LSU_LD, 4'h4, 8'h02, '0, 1'b0);
      issue(LSU_STF, 4'h2, 8'h00, '1, 1'b0);
      issue(LSU_ST, 4'h8, 8'h10, 80'h1, 1'b1);
      issue(LSU_ST, 4'h8, 8'h10, 80'h2, 1'b1);
      issue(LSU_LD, 4'h8, 8'h10, '0, 1'b1);
      issue(LSU_LD, 4'h8, 8'h00, '0, 1'b1);
      for (int j = 0; j < 400; j++)
      begin
         if (j % 50 == 0)
            set_order(1'($urandom));
         slow = 1'($urandom);
         k = lsu_kind_e'($urandom % 3);
         n = 4'(1 << ($urandom % 4));
         if (k == LSU_STF)
            n = (n == 4'h1) ? 4'hA : ((n == 4'h2) ? 4'h4 : n);
         a = 8'($urandom % 64) & ~((n == 4'hA) ? 8'h07 : 8'(n - 4'h1));
         issue(k, n, a, 80'({$urandom, $urandom, $urandom}), 1'b1);
      end
      print_verdict;
   end
endmodule : lsu_unit_test
